//--- src/rtca_alarm_ctrl.v
`timescale 1ns/100ps
`include "rtca_defs.vh"

module rtca_alarm_ctrl #(
  parameter HALF_SEC_CYCLES = `RTCA_HALF_SEC_CYCLES,
  parameter UNITS = `RTCA_UNITS
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire module_on,
  input wire [UNITS-1:0] unit_rollover,
  output wire half_tick,
  output wire alarm_pulse,
  output wire alarm_event,
  output wire irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Alarm control state.

  reg alarm_enable;
  reg chime;
  reg pulse_level;
  reg rollover_proximity_flag;
  reg [3:0] interval_select;
  reg [7:0] repeat_counter;
  reg [`RTCA_IRQ_W-1:0] irq_status;
  reg [`RTCA_IRQ_W-1:0] irq_mask;
  reg [31:0] half_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  reg wr_pend;
  reg rd_pend;
  reg rd_wait;
  reg [7:0] wr_addr;
  reg [7:0] rd_addr;
  wire addr_take;
  wire wr_ctrl;
  wire wr_stat;
  wire wr_mask;
  reg [31:0] read_mux;

  assign addr_take = hsel & hready & htrans[1];

  // Reads take one wait state so that a write just before them is already visible.
  assign hreadyout = ~rd_wait;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
    end else begin
      if (hready) begin
        wr_pend <= addr_take & hwrite;
        rd_pend <= addr_take & ~hwrite;
        if (addr_take) begin
          wr_addr <= haddr[7:0];
          rd_addr <= haddr[7:0];
        end
      end else begin
        wr_pend <= wr_pend;
        rd_pend <= rd_pend;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait <= 1'b0;
    end else if (addr_take & ~hwrite) begin
      rd_wait <= 1'b1;
    end else begin
      rd_wait <= 1'b0;
    end
  end

  assign wr_ctrl = wr_pend & (wr_addr == `RTCA_OFS_CTRL);
  assign wr_stat = wr_pend & (wr_addr == `RTCA_OFS_IRQ_STAT);
  assign wr_mask = wr_pend & (wr_addr == `RTCA_OFS_IRQ_MASK);

  always @* begin
    read_mux = 32'h0000_0000;
    case (rd_addr)
      `RTCA_OFS_CTRL: begin
        read_mux[`RTCA_BIT_ENABLE] = alarm_enable;
        read_mux[`RTCA_BIT_CHIME] = chime;
        read_mux[`RTCA_BIT_PIV] = pulse_level;
        read_mux[`RTCA_BIT_SYNC] = rollover_proximity_flag;
        read_mux[`RTCA_INTERVAL_HI:`RTCA_INTERVAL_LO] = interval_select;
        read_mux[`RTCA_REPEAT_HI:`RTCA_REPEAT_LO] = repeat_counter;
      end
      `RTCA_OFS_IRQ_STAT: begin
        read_mux[`RTCA_IRQ_W-1:0] = irq_status;
      end
      `RTCA_OFS_IRQ_MASK: begin
        read_mux[`RTCA_IRQ_W-1:0] = irq_mask;
      end
      default: begin
        read_mux = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_wait & rd_pend) begin
      hrdata <= read_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Half-second prescaler and rollover proximity.

  wire [31:0] half_last;
  wire near_rollover;

  assign half_last = HALF_SEC_CYCLES - 1;
  assign half_tick = module_on & (half_cnt == 32'h0000_0000);
  assign near_rollover = module_on & (half_cnt <= `RTCA_SYNC_WINDOW);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_cnt <= 32'h0000_0000;
    end else if (!module_on) begin
      half_cnt <= half_last;
    end else if (half_cnt == 32'h0000_0000) begin
      half_cnt <= half_last;
    end else begin
      half_cnt <= half_cnt - 32'h0000_0001;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rollover_proximity_flag <= 1'b0;
    end else begin
      // Flag clears once the count is more than the window away, or when module_on is low.
      rollover_proximity_flag <= near_rollover;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Alarm interval selection.

  wire interval_tick;

  rtca_event_gen #(
    .UNITS(UNITS)
  ) u_event_gen (
    .half_tick(half_tick),
    .unit_rollover(unit_rollover),
    .interval_select(interval_select),
    .interval_tick(interval_tick)
  );

  assign alarm_event = alarm_enable & interval_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // Alarm control register and repeat logic.

  wire count_zero;
  wire stop_now;
  reg next_enable;
  reg next_chime;
  reg next_pulse;
  reg [3:0] next_interval;
  reg [7:0] next_repeat;

  assign count_zero = (repeat_counter == `RTCA_REPEAT_ZERO);
  assign stop_now = alarm_event & count_zero & ~chime;

  always @* begin
    next_enable = alarm_enable;
    next_chime = chime;
    next_pulse = pulse_level;
    next_interval = interval_select;
    next_repeat = repeat_counter;
    if (wr_ctrl) begin
      next_enable = hwdata[`RTCA_BIT_ENABLE];
      next_chime = hwdata[`RTCA_BIT_CHIME];
      next_interval = hwdata[`RTCA_INTERVAL_HI:`RTCA_INTERVAL_LO];
      next_repeat = hwdata[`RTCA_REPEAT_HI:`RTCA_REPEAT_LO];
      if (!alarm_enable) begin
        next_pulse = hwdata[`RTCA_BIT_PIV];
      end
    end
    // An event in the same cycle as a write overrides the fields it touches.
    if (alarm_event) begin
      next_pulse = ~pulse_level;
      if (!count_zero) begin
        next_repeat = repeat_counter - 8'h01;
      end else if (chime) begin
        next_repeat = `RTCA_REPEAT_MAX;
      end else begin
        next_repeat = `RTCA_REPEAT_ZERO;
      end
    end
    if (stop_now) begin
      next_enable = 1'b0;
    end
  end

  // Only hresetn, the power-on reset, reaches these flops.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_enable <= 1'b0;
      chime <= 1'b0;
      pulse_level <= 1'b0;
      interval_select <= 4'h0;
      repeat_counter <= `RTCA_REPEAT_ZERO;
    end else begin
      alarm_enable <= next_enable;
      chime <= next_chime;
      pulse_level <= next_pulse;
      interval_select <= next_interval;
      repeat_counter <= next_repeat;
    end
  end

  assign alarm_pulse = pulse_level;

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts.

  wire [`RTCA_IRQ_W-1:0] irq_set;

  assign irq_set = {stop_now, alarm_event};

  // Hardware set wins over a write-one-to-clear in the same cycle.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= {`RTCA_IRQ_W{1'b0}};
      irq_mask <= {`RTCA_IRQ_W{1'b0}};
    end else begin
      if (wr_stat) begin
        irq_status <= (irq_status & ~hwdata[`RTCA_IRQ_W-1:0]) | irq_set;
      end else begin
        irq_status <= irq_status | irq_set;
      end
      if (wr_mask) begin
        irq_mask <= hwdata[`RTCA_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

endmodule // rtca_alarm_ctrl

//--- src/rtca_defs.vh
`ifndef RTCA_DEFS_VH
`define RTCA_DEFS_VH

// Register byte offsets.
`define RTCA_OFS_CTRL 8'h00
`define RTCA_OFS_IRQ_STAT 8'h04
`define RTCA_OFS_IRQ_MASK 8'h08

// Alarm control field positions.
`define RTCA_BIT_ENABLE 15
`define RTCA_BIT_CHIME 14
`define RTCA_BIT_PIV 13
`define RTCA_BIT_SYNC 12
`define RTCA_INTERVAL_HI 11
`define RTCA_INTERVAL_LO 8
`define RTCA_REPEAT_HI 7
`define RTCA_REPEAT_LO 0

// Interrupt status bit positions and width.
`define RTCA_IRQ_EVENT 0
`define RTCA_IRQ_DONE 1
`define RTCA_IRQ_W 2

// Reset and reload values.
`define RTCA_CTRL_RESET 16'h0000
`define RTCA_REPEAT_MAX 8'hff
`define RTCA_REPEAT_ZERO 8'h00

// Interval codes and unit count.
`define RTCA_INT_HALF 4'h0
`define RTCA_INT_YEAR 4'h9
`define RTCA_UNITS 9

// Timing.
`define RTCA_CLK_PERIOD_NS 25
`define RTCA_HALF_SEC_NS 500000000
`define RTCA_HALF_SEC_CYCLES (`RTCA_HALF_SEC_NS / `RTCA_CLK_PERIOD_NS)
`define RTCA_SYNC_WINDOW 32

`endif

//--- src/rtca_event_gen.v
`timescale 1ns/100ps
`include "rtca_defs.vh"

module rtca_event_gen #(
  parameter UNITS = `RTCA_UNITS
) (
  input wire half_tick,
  input wire [UNITS-1:0] unit_rollover,
  input wire [3:0] interval_select,
  output reg interval_tick
);

  // Code zero is the half-second itself; codes one to nine pick a unit rollover.
  always @* begin
    interval_tick = 1'b0;
    if (interval_select == `RTCA_INT_HALF) begin
      interval_tick = half_tick;
    end else if (interval_select <= `RTCA_INT_YEAR) begin
      interval_tick = half_tick & unit_rollover[interval_select - 4'h1];
    end else begin
      // Reserved codes never fire.
      interval_tick = 1'b0;
    end
  end

endmodule // rtca_event_gen

//--- tb/rtca_alarm_ctrl_asserts.sv
`timescale 1ns/100ps
module rtca_alarm_ctrl_asserts #(
  parameter HALF_SEC_CYCLES = 100,
  parameter UNITS = 9
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire module_on,
  input wire [UNITS-1:0] unit_rollover,
  input wire half_tick,
  input wire alarm_pulse,
  input wire alarm_event,
  input wire irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_rd_take;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence s_rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_read_wait;
    s_rd_take |=> s_rd_answer;
  endproperty
  property p_upper_zero;
    hreadyout |-> hrdata[31:16] == 16'h0000;
  endproperty
  property p_pulse_toggle;
    alarm_event |=> alarm_pulse != $past(alarm_pulse);
  endproperty
  property p_event_on_tick;
    alarm_event |-> half_tick;
  endproperty
  property p_event_single;
    alarm_event |=> !alarm_event;
  endproperty
  // Ticks must be far apart, else the proximity window would never close.
  property p_tick_gap;
    half_tick |=> !half_tick [*8];
  endproperty
  property p_tick_off;
    !module_on |-> !half_tick && !alarm_event;
  endproperty
  property p_reset_quiet;
    $rose(hresetn) |-> !alarm_pulse && !irq;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
  a_pulse_toggle: assert property (p_pulse_toggle) else $error("no toggle");
  a_event_on_tick: assert property (p_event_on_tick) else $error("event off tick");
  a_event_single: assert property (p_event_single) else $error("event too long");
  a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
  a_tick_off: assert property (p_tick_off) else $error("tick while off");
  a_reset_quiet: assert property (p_reset_quiet) else $error("reset value");
endmodule // rtca_alarm_ctrl_asserts

bind rtca_alarm_ctrl rtca_alarm_ctrl_asserts #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES), .UNITS(UNITS))
  rtca_alarm_ctrl_asserts_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .module_on(module_on),
  .unit_rollover(unit_rollover), .half_tick(half_tick), .alarm_pulse(alarm_pulse),
  .alarm_event(alarm_event), .irq(irq));

//--- tb/rtca_alarm_ctrl_test.sv
`timescale 1ns/100ps
module rtca_alarm_ctrl_test;
  localparam HALF = 200;
  reg hclk = 0;
  reg hresetn = 0;
  reg hsel = 0;
  reg [31:0] haddr = 0;
  reg [1:0] htrans = 0;
  reg hwrite = 0;
  reg [31:0] hwdata = 0;
  reg module_on = 0;
  reg [8:0] unit_rollover = 0;
  wire hready;
  wire [31:0] hrdata;
  wire half_tick, alarm_pulse, alarm_event, irq;
  integer fail_count = 0;
  integer total_checks = 0;
  integer ev_cnt = 0;
  integer i, e0;
  reg [31:0] rd;
  reg [7:0] ta [0:5] = '{8'h00, 8'h00, 8'h00, 8'h0c, 8'h08, 8'h08};
  reg [31:0] tw [0:5] = '{32'hffff_e9ab, 0, 32'h0000_1000, 32'hdead_beef, 3, 0};
  reg [31:0] te [0:5] = '{32'h0000_e9ab, 32'h0000_2000, 0, 0, 3, 0};
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) if (alarm_event === 1'h1) ev_cnt <= ev_cnt + 1;
  rtca_alarm_ctrl #(.HALF_SEC_CYCLES(HALF)) rtca_alarm_ctrl_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(),
    .module_on(module_on), .unit_rollover(unit_rollover), .half_tick(half_tick),
    .alarm_pulse(alarm_pulse), .alarm_event(alarm_event), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    begin
      $display("checks %0d fails %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task tmo;
    begin
      fail_count = fail_count + 1;
      end_of_test;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Ready is looked at before the edge, so the edge that accepts is never raced.
  task ack;
    integer n;
    begin
      n = 0;
      @(negedge hclk);
      while (hready !== 1'h1 && n < 31) begin
        n = n + 1;
        @(negedge hclk);
      end
      if (n == 31) tmo;
      rd = hrdata;
      @(posedge hclk);
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      ack;
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      ack;
    end
  endtask
  task waitev;
    integer n;
    begin
      n = 0;
      while (alarm_event !== 1'h1 && n < 250) begin
        n = n + 1;
        @(negedge hclk);
      end
      if (n == 250) tmo;
      @(posedge hclk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    bus(0, 0, 0);
    chk(rd, 0);
    chk({31'h0000_0000, alarm_pulse}, 0);
    for (i = 0; i < 6; i = i + 1) begin
      bus(1, ta[i], tw[i]);
      bus(0, ta[i], 0);
      chk(rd, te[i]);
    end
    $display("test table done");
    module_on <= 1'h1;
    bus(1, 0, 32'h0000_8001);
    @(posedge hclk);
    e0 = ev_cnt;
    repeat (3 * HALF) @(posedge hclk);
    chk(ev_cnt - e0, 2);
    bus(0, 0, 0);
    chk(rd & 32'hffff_efff, 0);
    bus(0, 8'h04, 0);
    chk(rd, 3);
    chk({31'h0000_0000, irq}, 0);
    bus(1, 8'h08, 3);
    // The write lands at the edge that ends the task, so look one edge later.
    @(posedge hclk);
    chk({31'h0000_0000, irq}, 1);
    bus(1, 8'h04, 3);
    @(posedge hclk);
    chk({31'h0000_0000, irq}, 0);
    $display("test auto disable done");
    bus(1, 0, 32'h0000_c000);
    waitev;
    bus(0, 0, 0);
    chk(rd, 32'h0000_e0ff);
    chk({31'h0000_0000, alarm_pulse}, 1);
    repeat (HALF - 30) @(posedge hclk);
    bus(0, 0, 0);
    chk(rd & 32'h0000_1000, 32'h0000_1000);
    bus(0, 0, 0);
    chk(rd & 32'h0000_1000, 32'h0000_1000);
    $display("test chime done");
    for (i = 1; i < 10; i = i + 1) begin
      bus(1, 0, 32'h0000_c0ff | (i << 8));
      unit_rollover <= ~(9'h001 << (i - 1));
      @(posedge hclk);
      e0 = ev_cnt;
      repeat (HALF) @(posedge hclk);
      chk(ev_cnt - e0, 0);
      unit_rollover <= 9'h001 << (i - 1);
      @(posedge hclk);
      e0 = ev_cnt;
      repeat (HALF) @(posedge hclk);
      chk(ev_cnt - e0, 1);
    end
    $display("test intervals done");
    module_on <= 1'h0;
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    bus(0, 0, 0);
    chk(rd, 0);
    $display("test reset done");
    end_of_test;
  end
endmodule // rtca_alarm_ctrl_test
